// *** hw/spi_port_pkg.sv ***
// constants for the serial register access port
//
// Function
// - output high impedance when idle or not reading
// - drive output while selected during reads
// - output stays released during writes
// - select high resets serial interface state
// - sample input data on rising clock
// - change output data on falling clock
// - bytes are eight bits, MSB first
// - first byte carries address bits 9..2
// - second byte: address 1..0, direction, ignored
// - data bytes auto-increment register address
// - strap high selects serial follower mode
// - strap low selects two-wire mode
// - address pins give unique two-wire address
// - standby keeps registers, chip enable reachable
package spi_port_pkg;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;
   localparam int NUM_REGS = 5;
   localparam logic [9:0] CHIP_ENABLE_CTRL_OFS = 10'h000;
   localparam logic [9:0] DEVICE_INITIAL_SETUP_OFS = 10'h001;
   localparam logic [9:0] DEVICE_CONFIG_ONE_OFS = 10'h002;
   localparam logic [9:0] DEVICE_CONFIG_TWO_OFS = 10'h003;
   localparam logic [9:0] DEVICE_CONFIG_THREE_OFS = 10'h004;
   localparam logic [7:0] CHIP_ENABLE_CTRL_RST = 8'h00;
   localparam logic [7:0] DEVICE_INITIAL_SETUP_RST = 8'h5E;
   localparam logic [7:0] DEVICE_CONFIG_ONE_RST = 8'h00;
   localparam logic [7:0] DEVICE_CONFIG_TWO_RST = 8'h00;
   localparam logic [7:0] DEVICE_CONFIG_THREE_RST = 8'h47;
   localparam int CHIP_EN_BIT = 0;
   localparam int DIR_BIT = 5;
   localparam logic DIR_WRITE = 1'b1;
   // two-wire follower address: fixed upper bits then the two pins
   localparam logic [2:0] TWO_WIRE_ADDR_HI = 3'h4;
   // time constants
   localparam int CLK_HZ = 40000000;
   localparam int SCLK_MAX_HZ = 12000000;
   // least system clocks per serial clock period, rounded up
   localparam int SCLK_MIN_CYC = (CLK_HZ + SCLK_MAX_HZ - 1) / SCLK_MAX_HZ;
   typedef enum logic [1:0] {ST_ADDR_HI, ST_ADDR_LO, ST_DATA} phase_t;
endpackage

// *** hw/spi_register_access_port.sv ***
// serial follower port over the device's register space
`timescale 1ns/100ps
`default_nettype none
module spi_register_access_port (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // serial link pins
   input wire logic sclk_i,
   input wire logic select_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   output logic miso_oe_n_o,
   // straps
   input wire logic interface_select_strap_i,
   input wire logic [1:0] follower_address_pins_i,
   // status
   output logic spi_mode_o,
   output logic [6:0] two_wire_address_o,
   output logic standby_o
);
   // three-stage input synchronisers; stage 1 read only by stage 2
   logic [2:0] sclk_s_reg, sel_s_reg, mosi_s_reg;
   logic [2:0] sclk_s_next, sel_s_next, mosi_s_next;
   logic sclk_q_reg, sel_q_reg, mosi_q_reg;
   logic sclk_q_next, sel_q_next, mosi_q_next;
   // serial state
   spi_port_pkg::phase_t phase_reg, phase_next;
   logic [2:0] bit_cnt_reg, bit_cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [9:0] addr_reg, addr_next;
   logic write_reg, write_next;
   logic reading_reg, reading_next;
   logic [7:0] tx_reg, tx_next;
   logic miso_reg, miso_next;
   logic oe_n_reg, oe_n_next;
   // registers
   logic [7:0] regs_reg [spi_port_pkg::NUM_REGS];
   logic [7:0] regs_next [spi_port_pkg::NUM_REGS];
   logic mode_reg, mode_next, strap_done_reg, strap_done_next;
   logic [6:0] twa_reg, twa_next;
   logic stby_reg, stby_next;
   // strap synchronisers and a fill counter so capture waits for stage three
   logic [2:0] strap_s_reg, strap_s_next;
   logic [1:0] pins_a_reg, pins_b_reg, pins_c_reg;
   logic [1:0] pins_a_next, pins_b_next, pins_c_next;
   logic [1:0] settle_reg, settle_next;
   logic rise, fall;
   logic [7:0] byte_in, rd_data;
   logic [9:0] rd_addr;

   // a change counts once stages two and three agree
   always_comb begin
      sclk_s_next = {sclk_s_reg[1:0], sclk_i};
      sel_s_next = {sel_s_reg[1:0], select_n_i};
      mosi_s_next = {mosi_s_reg[1:0], mosi_i};
      sclk_q_next = (sclk_s_reg[1] == sclk_s_reg[2]) ? sclk_s_reg[2]
                                                      : sclk_q_reg;
      sel_q_next = (sel_s_reg[1] == sel_s_reg[2]) ? sel_s_reg[2]
                                                   : sel_q_reg;
      mosi_q_next = (mosi_s_reg[1] == mosi_s_reg[2]) ? mosi_s_reg[2]
                                                      : mosi_q_reg;
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         sclk_s_reg <= 3'h0;
         sel_s_reg <= 3'h7;
         mosi_s_reg <= 3'h0;
         sclk_q_reg <= 1'b0;
         sel_q_reg <= 1'b1;
         mosi_q_reg <= 1'b0;
      end else begin
         sclk_s_reg <= sclk_s_next;
         sel_s_reg <= sel_s_next;
         mosi_s_reg <= mosi_s_next;
         sclk_q_reg <= sclk_q_next;
         sel_q_reg <= sel_q_next;
         mosi_q_reg <= mosi_q_next;
      end
   end

   // clock edges as seen after filtering
   assign rise = sclk_q_next & ~sclk_q_reg;
   assign fall = ~sclk_q_next & sclk_q_reg;
   assign byte_in = {shift_reg[6:0], mosi_q_reg};

   // read mux; in standby only chip enable is reachable
   always_comb begin
      // own address source keeps the mux out of a loop with the framer
      rd_addr = (phase_reg == spi_port_pkg::ST_ADDR_LO)
                ? {addr_reg[9:2], byte_in[7:6]} : addr_reg + 10'h1;
      rd_data = 8'h00;
      if (!stby_reg || rd_addr == spi_port_pkg::CHIP_ENABLE_CTRL_OFS) begin
         if (rd_addr < 10'(spi_port_pkg::NUM_REGS)) begin
            rd_data = regs_reg[rd_addr[2:0]];
         end
      end
   end

   // serial framing, address, data movement
   always_comb begin
      phase_next = phase_reg;
      bit_cnt_next = bit_cnt_reg;
      shift_next = shift_reg;
      addr_next = addr_reg;
      write_next = write_reg;
      reading_next = reading_reg;
      tx_next = tx_reg;
      miso_next = miso_reg;
      oe_n_next = oe_n_reg;
      regs_next = regs_reg;
      if (sel_q_reg || !mode_reg) begin
         // deselected: drop partial frame, release the line
         phase_next = spi_port_pkg::ST_ADDR_HI;
         bit_cnt_next = 3'h0;
         reading_next = 1'b0;
         oe_n_next = 1'b1;
         miso_next = 1'b0;
      end else begin
         if (rise) begin
            shift_next = byte_in;
            bit_cnt_next = bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
               unique case (phase_reg)
                  spi_port_pkg::ST_ADDR_HI: begin
                     addr_next = {byte_in, addr_reg[1:0]};
                     phase_next = spi_port_pkg::ST_ADDR_LO;
                  end
                  spi_port_pkg::ST_ADDR_LO: begin
                     // low bits ignored
                     addr_next = {addr_reg[9:2], byte_in[7:6]};
                     write_next = byte_in[spi_port_pkg::DIR_BIT];
                     phase_next = spi_port_pkg::ST_DATA;
                     if (byte_in[spi_port_pkg::DIR_BIT]
                         != spi_port_pkg::DIR_WRITE) begin
                        reading_next = 1'b1;
                        tx_next = rd_data;
                     end
                  end
                  spi_port_pkg::ST_DATA: begin
                     if (write_reg) begin
                        // commit on eighth bit, standby blocks all but enable
                        if (addr_reg < 10'(spi_port_pkg::NUM_REGS) &&
                            (!stby_reg || addr_reg ==
                             spi_port_pkg::CHIP_ENABLE_CTRL_OFS)) begin
                           regs_next[addr_reg[2:0]] = byte_in;
                        end
                     end else begin
                        tx_next = rd_data;
                     end
                     addr_next = addr_reg + 10'h1;
                  end
                  default: phase_next = spi_port_pkg::ST_ADDR_HI;
               endcase
            end
         end
         if (fall && reading_reg) begin
            // shift out MSB first on falling edge
            miso_next = tx_reg[7];
            tx_next = {tx_reg[6:0], 1'b0};
            oe_n_next = 1'b0;
         end
         if (!reading_reg) begin
            oe_n_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         phase_reg <= spi_port_pkg::ST_ADDR_HI;
         bit_cnt_reg <= 3'h0;
         shift_reg <= 8'h00;
         addr_reg <= 10'h000;
         write_reg <= 1'b0;
         reading_reg <= 1'b0;
         tx_reg <= 8'h00;
         miso_reg <= 1'b0;
         oe_n_reg <= 1'b1;
         regs_reg[0] <= spi_port_pkg::CHIP_ENABLE_CTRL_RST;
         regs_reg[1] <= spi_port_pkg::DEVICE_INITIAL_SETUP_RST;
         regs_reg[2] <= spi_port_pkg::DEVICE_CONFIG_ONE_RST;
         regs_reg[3] <= spi_port_pkg::DEVICE_CONFIG_TWO_RST;
         regs_reg[4] <= spi_port_pkg::DEVICE_CONFIG_THREE_RST;
      end else begin
         phase_reg <= phase_next;
         bit_cnt_reg <= bit_cnt_next;
         shift_reg <= shift_next;
         addr_reg <= addr_next;
         write_reg <= write_next;
         reading_reg <= reading_next;
         tx_reg <= tx_next;
         miso_reg <= miso_next;
         oe_n_reg <= oe_n_next;
         regs_reg <= regs_next;
      end
   end

   // straps caught once, after three stages filled and two and three agree
   always_comb begin
      strap_s_next = {strap_s_reg[1:0], interface_select_strap_i};
      pins_a_next = follower_address_pins_i;
      pins_b_next = pins_a_reg;
      pins_c_next = pins_b_reg;
      settle_next = (settle_reg == 2'h3) ? settle_reg : settle_reg + 2'h1;
      strap_done_next = strap_done_reg;
      mode_next = mode_reg;
      twa_next = twa_reg;
      if (!strap_done_reg && settle_reg == 2'h3 &&
          strap_s_reg[1] == strap_s_reg[2] && pins_b_reg == pins_c_reg) begin
         strap_done_next = 1'b1;
         mode_next = strap_s_reg[2];
         twa_next = {spi_port_pkg::TWO_WIRE_ADDR_HI, 2'h0,
                     pins_c_reg};
      end
      stby_next = ~regs_reg[0][spi_port_pkg::CHIP_EN_BIT];
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         strap_s_reg <= 3'h0;
         pins_a_reg <= 2'h0;
         pins_b_reg <= 2'h0;
         pins_c_reg <= 2'h0;
         settle_reg <= 2'h0;
         strap_done_reg <= 1'b0;
         mode_reg <= 1'b0;
         twa_reg <= 7'h00;
         stby_reg <= 1'b1;
      end else begin
         strap_s_reg <= strap_s_next;
         pins_a_reg <= pins_a_next;
         pins_b_reg <= pins_b_next;
         pins_c_reg <= pins_c_next;
         settle_reg <= settle_next;
         strap_done_reg <= strap_done_next;
         mode_reg <= mode_next;
         twa_reg <= twa_next;
         stby_reg <= stby_next;
      end
   end

   assign miso_o = miso_reg;
   assign miso_oe_n_o = oe_n_reg;
   assign spi_mode_o = mode_reg;
   assign two_wire_address_o = twa_reg;
   assign standby_o = stby_reg;

   // checks
   a_idle_released: assert property (@(posedge clock_i) disable iff (rst_i)
      sel_q_reg |=> miso_oe_n_o)
      else $error("miso driven while deselected");
   a_write_released: assert property (@(posedge clock_i) disable iff (rst_i)
      (write_reg && phase_reg == spi_port_pkg::ST_DATA) |-> miso_oe_n_o)
      else $error("miso driven during write");
   a_drive_on_fall: assert property (@(posedge clock_i) disable iff (rst_i)
      (fall && reading_reg && !sel_q_reg && mode_reg) |=> !miso_oe_n_o)
      else $error("read not driven");
   a_out_only_fall: assert property (@(posedge clock_i) disable iff (rst_i)
      (!fall && !sel_q_reg && reading_reg) |=> $stable(miso_o))
      else $error("miso changed off falling edge");
   a_deselect_reset: assert property (@(posedge clock_i) disable iff (rst_i)
      sel_q_reg |=> (bit_cnt_reg == 3'h0 &&
                     phase_reg == spi_port_pkg::ST_ADDR_HI))
      else $error("frame not reset");
   a_count_on_rise: assert property (@(posedge clock_i) disable iff (rst_i)
      (rise && !sel_q_reg && mode_reg) |=>
      bit_cnt_reg == $past(bit_cnt_reg) + 3'h1)
      else $error("bit not counted");
   a_addr_advance: assert property (@(posedge clock_i) disable iff (rst_i)
      (rise && !sel_q_reg && mode_reg && bit_cnt_reg == 3'h7 &&
       phase_reg == spi_port_pkg::ST_DATA) |=>
      addr_reg == $past(addr_reg) + 10'h1)
      else $error("address not advanced");
   a_strap_held: assert property (@(posedge clock_i) disable iff (rst_i)
      strap_done_reg |=> $stable(spi_mode_o))
      else $error("mode changed after capture");
   a_standby_block: assert property (@(posedge clock_i) disable iff (rst_i)
      (stby_reg && write_reg && rise && bit_cnt_reg == 3'h7 &&
       phase_reg == spi_port_pkg::ST_DATA && !sel_q_reg && mode_reg &&
       addr_reg != spi_port_pkg::CHIP_ENABLE_CTRL_OFS) |=>
      ($stable(regs_reg[1]) && $stable(regs_reg[2]) &&
       $stable(regs_reg[3]) && $stable(regs_reg[4])))
      else $error("write landed in standby");
   c_read: cover property (@(posedge clock_i) reading_reg && fall);
   c_write: cover property (@(posedge clock_i)
      write_reg && phase_reg == spi_port_pkg::ST_DATA && rise);
   c_abort: cover property (@(posedge clock_i)
      bit_cnt_reg != 3'h0 && sel_q_next && !sel_q_reg);
endmodule // spi_register_access_port
`default_nettype wire

// *** sim/spi_host_model.sv ***
// behavioural spi leader that frames transfers on the serial port
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
   // clock
   input wire logic clock_i,
   // serial pins
   output logic sclk_o,
   output logic select_n_o,
   output logic mosi_o,
   input wire logic miso_i,
   input wire logic miso_oe_n_i
);
   // idle: serial clock parked low, device not selected
   initial begin
      sclk_o = 1'b0;
      select_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // select held steady with margin around the transfer
   task automatic sel(input logic lvl);
      repeat (8) @(negedge clock_i);
      select_n_o = lvl;
      mosi_o = ~mosi_o; // idle data keeps moving
      repeat (8) @(negedge clock_i);
   endtask
   // msb first, 15 clocks per bit keeps well under max rate
   task automatic xfer(input logic [7:0] tx, input int nb,
      output logic [7:0] rx, output logic [7:0] oe);
      rx = 8'h00;
      oe = 8'hFF;
      for (int i = 7; i >= 8 - nb; i--) begin
         @(negedge clock_i);
         sclk_o = 1'b0;
         mosi_o = tx[i];
         repeat (7) @(negedge clock_i);
         rx[i] = miso_i; // taken just before the rising edge
         oe[i] = miso_oe_n_i;
         sclk_o = 1'b1;
         repeat (7) @(negedge clock_i);
      end
      @(negedge clock_i);
      sclk_o = 1'b0;
   endtask
endmodule // spi_host_model
`default_nettype wire

// *** sim/tb_top.sv ***
// testbench for the serial register access port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clock_i, rst_i, sclk, sel_n, mosi, miso, oe_n, strap, spi_mode;
   logic standby, miso_w;
   logic [1:0] pins;
   logic [6:0] tw_addr;
   logic [7:0] rx, oe;
   int n_mismatch = 0;
   int cmp_count = 0;
   // no pull on the line: a released output shows the inverse, never stale
   assign miso_w = oe_n ? ~miso : miso;
   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   spi_register_access_port dut (.clock_i(clock_i), .rst_i(rst_i),
      .sclk_i(sclk), .select_n_i(sel_n), .mosi_i(mosi), .miso_o(miso),
      .miso_oe_n_o(oe_n), .interface_select_strap_i(strap),
      .follower_address_pins_i(pins), .spi_mode_o(spi_mode),
      .two_wire_address_o(tw_addr), .standby_o(standby));
   spi_host_model host (.clock_i(clock_i), .sclk_o(sclk),
      .select_n_o(sel_n), .mosi_o(mosi), .miso_i(miso_w),
      .miso_oe_n_i(oe_n));
   task automatic check(input string nm, input logic [7:0] seen,
      input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one transaction; d holds up to four bytes, first byte on top
   task automatic frame(input logic [9:0] a, input logic wr, input int n,
      input logic [31:0] d);
      host.sel(1'b0);
      host.xfer(a[9:2], 8, rx, oe);
      check("oe byte1", oe, 8'hFF);
      host.xfer({a[1:0], wr, 5'h15}, 8, rx, oe);
      check("oe byte2", oe, 8'hFF);
      for (int i = 0; i < n; i++) begin
         host.xfer(wr ? d[31-8*i -: 8] : 8'hA5, 8, rx, oe);
         if (wr) check("oe write", oe, 8'hFF);
         else begin
            check("oe read", oe, 8'h00);
            check("rd data", rx, d[31-8*i -: 8]);
         end
      end
      host.sel(1'b1);
   endtask
   task automatic do_reset(input logic s, input logic [1:0] p);
      rst_i = 1'b1;
      strap = s;
      pins = p;
      repeat (8) @(negedge clock_i);
      rst_i = 1'b0;
      repeat (10) @(negedge clock_i);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (60000) @(posedge clock_i);
      n_mismatch++;
      give_verdict();
   end
   initial begin
      do_reset(1'b1, 2'b01);
      check("spi mode", {7'h00, spi_mode}, 8'h01);
      check("tw addr", {1'b0, tw_addr}, 8'h41);
      check("standby", {7'h00, standby}, 8'h01);
      frame(10'h001, 1'b0, 1, 32'h0);
      frame(10'h000, 1'b1, 1, 32'h01000000);
      frame(10'h000, 1'b0, 1, 32'h01000000);
      check("standby", {7'h00, standby}, 8'h00);
      frame(10'h001, 1'b0, 4, 32'h5E000047);
      $display("test reset values done");
      frame(10'h001, 1'b1, 4, 32'hC3813C7E);
      frame(10'h001, 1'b0, 4, 32'hC3813C7E);
      $display("test burst done");
      // deselect half way through a data byte of a write to offset 3
      host.sel(1'b0);
      host.xfer(8'h00, 8, rx, oe);
      host.xfer(8'hE0, 8, rx, oe);
      host.xfer(8'h00, 4, rx, oe);
      host.sel(1'b1);
      frame(10'h003, 1'b0, 1, 32'h3C000000);
      $display("test abort done");
      frame(10'h000, 1'b1, 1, 32'h0);
      frame(10'h002, 1'b1, 1, 32'h55000000); // dropped
      frame(10'h000, 1'b1, 1, 32'h01000000);
      frame(10'h002, 1'b0, 1, 32'h81000000);
      $display("test standby done");
      do_reset(1'b0, 2'b10);
      check("spi mode", {7'h00, spi_mode}, 8'h00);
      check("tw addr", {1'b0, tw_addr}, 8'h42);
      host.sel(1'b0);
      host.xfer(8'h00, 8, rx, oe);
      host.xfer(8'h00, 8, rx, oe);
      host.xfer(8'h00, 8, rx, oe);
      check("oe inert", oe, 8'hFF);
      host.sel(1'b1);
      $display("test two-wire strap done");
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire
